// file: emb_pkg.sv
package emb_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned OSC_PER_MCYCLE = 12;
    localparam int unsigned OSC_PER_ALE = 6;
    localparam int unsigned RST_MIN_MCYCLES = 2;
    localparam int unsigned RST_MIN_OSC = RST_MIN_MCYCLES * OSC_PER_MCYCLE;
    localparam logic [3:0] MC_LAST = 4'(OSC_PER_MCYCLE - 1);
    localparam logic [2:0] SP_LAST = 3'(OSC_PER_ALE - 1);
    localparam logic [2:0] SP_ALE_ON = 3'h1;
    localparam logic [2:0] SP_ALE_OFF = 3'h2;
    localparam logic [2:0] SP_ADDR_LAST = 3'h3;
    localparam logic [2:0] SP_STROBE = 3'h4;
    // ----------------------------------------
    // Address map and reset values
    // ----------------------------------------
    localparam logic [15:0] INT_CODE_TOP = 16'h3fff;
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // ----------------------------------------
    // Alternate pin positions
    // ----------------------------------------
    localparam int unsigned P1_T2CLK = 0;
    localparam int unsigned P1_T2TRIG = 1;
    localparam int unsigned P3_RXD = 0;
    localparam int unsigned P3_TXD = 1;
    localparam int unsigned P3_IRQ0 = 2;
    localparam int unsigned P3_IRQ1 = 3;
    localparam int unsigned P3_TMR0 = 4;
    localparam int unsigned P3_TMR1 = 5;
    localparam int unsigned P3_WR = 6;
    localparam int unsigned P3_RD = 7;
    localparam int unsigned VERIFY_HI_BITS = 6;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef logic [7:0] emb_byte_t;
    typedef logic [15:0] emb_addr_t;
    typedef enum logic [4:0] {
        SL_NONE      = 5'b00001,
        SL_CODE_INT  = 5'b00010,
        SL_CODE_EXT  = 5'b00100,
        SL_DATA_ADDR = 5'b01000,
        SL_DATA_XFER = 5'b10000
    } emb_slot_t;
endpackage

// file: emb_phase_gen.sv
`timescale 1ns/1ns
`default_nettype none
module emb_phase_gen
(
    input wire logic clock,
    input wire logic rst,
    output logic [3:0] mcyclePhase,
    output logic [2:0] slotPhase
);
    import emb_pkg::*;

    logic [3:0] mc_q;
    logic [2:0] sp_q;

    // (RL20) Twelve clocks per machine cycle
    always_ff @(posedge clock)
    begin
        if (rst || mc_q == MC_LAST)
            mc_q <= 4'h0;
        else
            mc_q <= mc_q + 4'h1;
    end

    // Two address slots per machine cycle
    always_ff @(posedge clock)
    begin
        if (rst || sp_q == SP_LAST)
            sp_q <= 3'h0;
        else
            sp_q <= sp_q + 3'h1;
    end

    assign mcyclePhase = mc_q;
    assign slotPhase = sp_q;
endmodule
`default_nettype wire

// file: emb_port_pad.sv
`timescale 1ns/1ns
`default_nettype none
module emb_port_pad
#(
    parameter bit OPEN_DRAIN = 1'b0
)
(
    input wire logic clock,
    input wire logic rst,
    input wire emb_pkg::emb_byte_t latch,
    input wire logic busEn,
    input wire emb_pkg::emb_byte_t busByte,
    input wire logic busFloat,
    output emb_pkg::emb_byte_t padOut,
    output emb_pkg::emb_byte_t padOeN
);
    import emb_pkg::*;

    emb_byte_t out_q;
    emb_byte_t oeN_q;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            out_q <= PORT_RESET;
            oeN_q <= PORT_RESET;
        end
        // (RL3) Bus use drives ones strongly
        else if (busEn)
        begin
            out_q <= busByte;
            oeN_q <= BYTE_ZERO;
        end
        else if (busFloat)
        begin
            out_q <= PORT_RESET;
            oeN_q <= PORT_RESET;
        end
        // (RL2) Latch one releases the pin
        else
        begin
            out_q <= latch;
            oeN_q <= latch;
        end
    end

    // (RL10) Reset releases pullup ports without waiting for an edge
    assign padOut = out_q;
    assign padOeN = OPEN_DRAIN ? oeN_q : (oeN_q | {8{rst}});
endmodule
`default_nettype wire

// file: emb_bus_port_ctrl.sv
// How it works
// (RL1) Port 0 multiplexes low address and data for external accesses.
// (RL2) Port 0 bits with latch one are released, high-impedance inputs.
// (RL3) Port 0 drives ones strongly while acting as the bus.
// (RL4) Ports 1-3 release latch-one pins to a weak pullup, readable as inputs.
// (RL5) P1 bit 0 is timer 2 clock, bit 1 its trigger.
// (RL6) Port 2 drives high address for code fetches and wide-pointer data.
// (RL7) Index-register data accesses keep port 2 showing its latch.
// (RL8) Port 3 bits carry serial, interrupts, timers, write and read strobes.
// (RL9) Outside reset is held at least two machine cycles.
// (RL10) Reset forces ports 1-3 to one without a clock edge.
// (RL11) ALE marks the low address byte on port 0.
// (RL12) ALE pulses every six clocks, even without external access.
// (RL13) Each external data access skips exactly one ALE pulse.
// (RL14) External code fetch asserts the program strobe twice per machine cycle.
// (RL15) Each data access skips two program strobe pulses.
// (RL16) Internal code fetches never assert the program strobe.
// (RL17) Select high: internal up to 3fff, else external; low: external only.
// (RL18) The access select pin is always driven high or low.
// (RL19) Verify mode: code out on port 0, address in on ports 1 and 2.
// (RL20) A machine cycle is twelve clocks; minimum reset is 24.
// (RL21) External latch takes low address on ALE fall, then port 0 is data.
`timescale 1ns/1ns
`default_nettype none
module emb_bus_port_ctrl
(
    input wire logic clock,
    input wire logic rst,
    input wire logic extAccessSelect,
    input wire logic progVerify,
    input wire logic fetchReq,
    input wire emb_pkg::emb_addr_t fetchAddr,
    output emb_pkg::emb_byte_t codeByte,
    output logic codeValid,
    input wire logic dataReq,
    input wire logic dataWrite,
    input wire logic dataWide,
    input wire emb_pkg::emb_addr_t dataAddr,
    input wire emb_pkg::emb_byte_t dataWrByte,
    output emb_pkg::emb_byte_t dataRdByte,
    output logic dataDone,
    output logic dataBusy,
    input wire logic [3:0] latchWe,
    input wire emb_pkg::emb_byte_t latchWrByte,
    output emb_pkg::emb_byte_t p0Read,
    output emb_pkg::emb_byte_t p1Read,
    output emb_pkg::emb_byte_t p2Read,
    output emb_pkg::emb_byte_t p3Read,
    input wire logic serialTxd,
    output logic serialRxd,
    output logic extIrq0Pin,
    output logic extIrq1Pin,
    output logic timer0ExtInput,
    output logic timer1ExtInput,
    output logic timer2ClockInput,
    output logic timer2TriggerInput,
    output emb_pkg::emb_addr_t intRomAddr,
    input wire emb_pkg::emb_byte_t intRomData,
    output logic addrLatchStrobe,
    output logic progStoreStrobeN,
    input wire emb_pkg::emb_byte_t p0In,
    output emb_pkg::emb_byte_t p0Out,
    output emb_pkg::emb_byte_t p0OeN,
    input wire emb_pkg::emb_byte_t p1In,
    output emb_pkg::emb_byte_t p1Out,
    output emb_pkg::emb_byte_t p1OeN,
    input wire emb_pkg::emb_byte_t p2In,
    output emb_pkg::emb_byte_t p2Out,
    output emb_pkg::emb_byte_t p2OeN,
    input wire emb_pkg::emb_byte_t p3In,
    output emb_pkg::emb_byte_t p3Out,
    output emb_pkg::emb_byte_t p3OeN
);
    import emb_pkg::*;

    function automatic logic isInternal(input logic sel, input emb_addr_t addr);
        isInternal = sel && (addr <= INT_CODE_TOP);
    endfunction

    // ----------------------------------------
    // Timing and slot sequencing
    // ----------------------------------------
    logic [3:0] mcPhase;
    logic [2:0] sp;
    emb_slot_t slot_q;
    emb_slot_t slot_d;
    emb_addr_t slotAddr_q;
    logic slotEnd;

    emb_phase_gen u_phase
    (
        .clock(clock),
        .rst(rst),
        .mcyclePhase(mcPhase),
        .slotPhase(sp)
    );

    assign slotEnd = (sp == SP_LAST);

    logic dataPend_q;
    logic dataWrite_q;
    logic dataWide_q;
    emb_addr_t dataAddr_q;
    emb_byte_t dataWrByte_q;
    logic dataBusy_q;

    always_comb
    begin
        slot_d = SL_NONE;
        if (slot_q == SL_DATA_ADDR)
            slot_d = SL_DATA_XFER;
        else if (progVerify)
            slot_d = SL_NONE;
        else if (dataPend_q)
            slot_d = SL_DATA_ADDR;
        // (RL17) Internal or external fetch select
        else if (fetchReq)
            slot_d = isInternal(extAccessSelect, fetchAddr) ? SL_CODE_INT : SL_CODE_EXT;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            slot_q <= SL_NONE;
            slotAddr_q <= 16'h0000;
        end
        else if (slotEnd)
        begin
            slot_q <= slot_d;
            if (slot_d == SL_DATA_ADDR)
                slotAddr_q <= dataAddr_q;
            else if (slot_d != SL_DATA_XFER)
                slotAddr_q <= fetchAddr;
        end
    end

    // Requests arriving while busy are dropped; core waits for dataDone
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            dataPend_q <= 1'b0;
            dataWrite_q <= 1'b0;
            dataWide_q <= 1'b0;
            dataAddr_q <= 16'h0000;
            dataWrByte_q <= BYTE_ZERO;
        end
        else if (dataReq && !dataBusy_q)
        begin
            dataPend_q <= 1'b1;
            dataWrite_q <= dataWrite;
            dataWide_q <= dataWide;
            dataAddr_q <= dataAddr;
            dataWrByte_q <= dataWrByte;
        end
        else if (slotEnd && slot_d == SL_DATA_ADDR)
            dataPend_q <= 1'b0;
    end

    logic xferEnd;
    assign xferEnd = (slot_q == SL_DATA_XFER) && slotEnd;

    always_ff @(posedge clock)
    begin
        if (rst || xferEnd)
            dataBusy_q <= 1'b0;
        else if (dataReq)
            dataBusy_q <= 1'b1;
    end

    // ----------------------------------------
    // Port latches
    // ----------------------------------------
    emb_byte_t latch_q [4];

    for (genvar i = 0; i < 4; i++)
    begin : g_latch
        always_ff @(posedge clock)
        begin
            if (rst)
                latch_q[i] <= PORT_RESET;
            else if (latchWe[i])
                latch_q[i] <= latchWrByte;
        end
    end

    // ----------------------------------------
    // Strobes
    // ----------------------------------------
    logic ale_q;
    logic psenN_q;
    logic strobeOn;

    assign strobeOn = (slot_q == SL_DATA_XFER) || (slot_q == SL_DATA_ADDR && sp >= SP_STROBE);

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ale_q <= 1'b0;
            psenN_q <= 1'b1;
        end
        else
        begin
            // (RL12) Free-running; (RL13) skipped in the transfer slot
            ale_q <= (sp == SP_ALE_ON || sp == SP_ALE_OFF) && slot_q != SL_DATA_XFER;
            // (RL14) Two per machine cycle; (RL15) (RL16) external code slots only
            psenN_q <= !(slot_q == SL_CODE_EXT && sp >= SP_STROBE);
        end
    end

    // ----------------------------------------
    // Pin drive selection
    // ----------------------------------------
    emb_byte_t padLatch [4];
    logic padBusEn [4];
    emb_byte_t padBusByte [4];
    logic padFloat [4];
    emb_byte_t padOut [4];
    emb_byte_t padOeN [4];
    emb_byte_t p3Alt;
    logic addrPhase;
    logic extCycle;
    logic wideHigh;

    assign addrPhase = (sp <= SP_ADDR_LAST);
    assign extCycle = (slot_q == SL_CODE_EXT) || (slot_q == SL_DATA_ADDR) ||
                      (slot_q == SL_DATA_XFER);
    assign wideHigh = (slot_q == SL_CODE_EXT) ||
                      (dataWide_q && (slot_q == SL_DATA_ADDR || slot_q == SL_DATA_XFER));

    always_comb
    begin
        p3Alt = PORT_RESET;
        p3Alt[P3_TXD] = serialTxd;
        // Pad flop is the only delay, so the strobe ends with the data
        p3Alt[P3_WR] = !(strobeOn && dataWrite_q);
        p3Alt[P3_RD] = !(strobeOn && !dataWrite_q);
    end

    always_comb
    begin
        // (RL19) Code byte out as open drain, pullups outside
        padLatch[0] = progVerify ? intRomData : latch_q[0];
        padBusEn[0] = 1'b0;
        padBusByte[0] = slotAddr_q[7:0];
        padFloat[0] = 1'b0;
        // (RL1) Low address, then data or float
        if (extCycle)
        begin
            if (slot_q != SL_DATA_XFER && addrPhase)
                padBusEn[0] = 1'b1;
            else if (dataWrite_q && slot_q != SL_CODE_EXT)
            begin
                padBusEn[0] = 1'b1;
                padBusByte[0] = dataWrByte_q;
            end
            else
                padFloat[0] = 1'b1;
        end
    end

    // (RL19) Ports 1 and 2 released as address inputs in verify mode
    assign padLatch[1] = progVerify ? PORT_RESET : latch_q[1];
    assign padBusEn[1] = 1'b0;
    assign padBusByte[1] = BYTE_ZERO;
    assign padFloat[1] = 1'b0;

    // (RL6) High address; (RL7) latch otherwise
    assign padLatch[2] = progVerify ? PORT_RESET : latch_q[2];
    assign padBusEn[2] = wideHigh;
    assign padBusByte[2] = slotAddr_q[15:8];
    assign padFloat[2] = 1'b0;

    // (RL8) Alternate outputs gate the latch
    assign padLatch[3] = latch_q[3] & p3Alt;
    assign padBusEn[3] = 1'b0;
    assign padBusByte[3] = BYTE_ZERO;
    assign padFloat[3] = 1'b0;

    // (RL4) Quasi-bidirectional pads on ports 1-3; port 0 pad is open drain
    for (genvar i = 0; i < 4; i++)
    begin : g_pad
        emb_port_pad #(.OPEN_DRAIN(i == 0)) u_pad
        (
            .clock(clock),
            .rst(rst),
            .latch(padLatch[i]),
            .busEn(padBusEn[i]),
            .busByte(padBusByte[i]),
            .busFloat(padFloat[i]),
            .padOut(padOut[i]),
            .padOeN(padOeN[i])
        );
    end

    // ----------------------------------------
    // Captures
    // ----------------------------------------
    emb_byte_t code_q;
    logic codeValid_q;
    emb_byte_t rdByte_q;
    logic done_q;
    emb_addr_t romAddr_q;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            code_q <= BYTE_ZERO;
            codeValid_q <= 1'b0;
            rdByte_q <= BYTE_ZERO;
            done_q <= 1'b0;
        end
        else
        begin
            codeValid_q <= slotEnd && (slot_q == SL_CODE_EXT || slot_q == SL_CODE_INT);
            done_q <= xferEnd;
            if (slotEnd && slot_q == SL_CODE_EXT)
                code_q <= p0In;
            else if (slotEnd && slot_q == SL_CODE_INT)
                code_q <= intRomData;
            if (xferEnd && !dataWrite_q)
                rdByte_q <= p0In;
        end
    end

    // Sampled every clock in verify mode so the pins set the address
    always_ff @(posedge clock)
    begin
        if (rst)
            romAddr_q <= 16'h0000;
        else if (progVerify)
            romAddr_q <= {2'b00, p2In[VERIFY_HI_BITS-1:0], p1In};
        else if (slotEnd)
            romAddr_q <= fetchAddr;
    end

    emb_byte_t pinRead_q [4];
    logic [6:0] alt_q;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pinRead_q[0] <= PORT_RESET;
            pinRead_q[1] <= PORT_RESET;
            pinRead_q[2] <= PORT_RESET;
            pinRead_q[3] <= PORT_RESET;
            alt_q <= 7'h7f;
        end
        else
        begin
            pinRead_q[0] <= p0In;
            pinRead_q[1] <= p1In;
            pinRead_q[2] <= p2In;
            pinRead_q[3] <= p3In;
            // (RL8) Alternate inputs; (RL5) timer 2 pins on port 1
            alt_q <= {p1In[P1_T2TRIG], p1In[P1_T2CLK], p3In[P3_TMR1], p3In[P3_TMR0],
                      p3In[P3_IRQ1], p3In[P3_IRQ0], p3In[P3_RXD]};
        end
    end

    assign codeByte = code_q;
    assign codeValid = codeValid_q;
    assign dataRdByte = rdByte_q;
    assign dataDone = done_q;
    assign dataBusy = dataBusy_q;
    assign p0Read = pinRead_q[0];
    assign p1Read = pinRead_q[1];
    assign p2Read = pinRead_q[2];
    assign p3Read = pinRead_q[3];
    assign {timer2TriggerInput, timer2ClockInput, timer1ExtInput, timer0ExtInput,
            extIrq1Pin, extIrq0Pin, serialRxd} = alt_q;
    assign intRomAddr = romAddr_q;
    // (RL11) Low address valid around the ALE fall
    assign addrLatchStrobe = ale_q;
    assign progStoreStrobeN = psenN_q;
    assign p0Out = padOut[0];
    assign p0OeN = padOeN[0];
    assign p1Out = padOut[1];
    assign p1OeN = padOeN[1];
    assign p2Out = padOut[2];
    assign p2OeN = padOeN[2];
    assign p3Out = padOut[3];
    assign p3OeN = padOeN[3];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_ale_width: assert property ($rose(ale_q) |-> ##1 ale_q ##1 !ale_q) // RL12
        else $error("ale pulse not two clocks");
    a_ale_period: assert property ($rose(ale_q) && slot_q != SL_DATA_ADDR |-> ##6 $rose(ale_q)) // RL12
        else $error("ale pulse missing");
    a_ale_skip: assert property (slot_q == SL_DATA_XFER && sp == 3'h2 |-> !ale_q) // RL13
        else $error("ale not skipped in data access");
    a_prog_store_strobe_ext_only: assert property ($fell(psenN_q) |-> $past(slot_q) == SL_CODE_EXT) // RL16
        else $error("program strobe outside external fetch");
    a_prog_store_strobe_width: assert property ($fell(psenN_q) |-> ##1 !psenN_q ##1 psenN_q) // RL14
        else $error("program strobe width wrong");
    a_prog_store_strobe_skip: assert property (strobeOn |-> psenN_q) // RL15
        else $error("program strobe during data access");
    a_fetch_select: assert property (slot_q == SL_CODE_INT |-> isInternal(extAccessSelect, slotAddr_q)) // RL17
        else $error("internal fetch outside internal range");
    a_p0_addr: assert property (slot_q == SL_CODE_EXT && sp == 3'h1 |-> ##1 (p0OeN == BYTE_ZERO && p0Out == slotAddr_q[7:0])) // RL1
        else $error("port 0 low address not driven");
    a_p2_high: assert property (slot_q == SL_CODE_EXT && sp == 3'h2 |-> ##1 (p2OeN == BYTE_ZERO && p2Out == slotAddr_q[15:8])) // RL6
        else $error("port 2 high address not driven");
    a_p2_latch: assert property (slot_q == SL_DATA_XFER && !dataWide_q && !progVerify && $stable(latch_q[2]) |-> ##1 p2Out == $past(latch_q[2])) // RL7
        else $error("port 2 left its latch");
    a_read_strobe: assert property ($fell(p3Out[P3_RD]) |-> ##7 !p3Out[P3_RD] ##1 p3Out[P3_RD]) // RL8
        else $error("read strobe length wrong");
    a_reset_ports: assert property (@(posedge clock) disable iff (1'b0) rst |-> (p1OeN & p2OeN & p3OeN) == PORT_RESET) // RL10
        else $error("ports not released in reset");

    c_ext_fetch: cover property (slot_q == SL_CODE_EXT ##6 slot_q == SL_CODE_EXT);
    c_data_read: cover property (xferEnd && !dataWrite_q);
    c_data_write: cover property (xferEnd && dataWrite_q);
    c_mcycle_wrap: cover property (mcPhase == MC_LAST && progVerify);
endmodule
`default_nettype wire

// file: emb_ext_mem.sv
`timescale 1ns/1ns
`default_nettype none
module emb_ext_mem
(
    input wire logic clock,
    input wire logic ale,
    input wire logic progStrobeN,
    input wire logic readN,
    input wire logic writeN,
    input wire emb_pkg::emb_byte_t p0Out,
    input wire emb_pkg::emb_byte_t p0OeN,
    input wire emb_pkg::emb_byte_t p2Pin,
    output emb_pkg::emb_byte_t p0Pin
);
    import emb_pkg::*;
    emb_addr_t addrQ = '0;
    emb_byte_t store [emb_addr_t];
    emb_byte_t memOut;
    // Every place answers a pattern of its address; written bytes are only recorded, never read back
    assign memOut = (!progStrobeN || !readN) ? (addrQ[7:0] ^ addrQ[15:8] ^ 8'h5a) : 8'hff;
    // Released bits show the memory during a strobe, else the board pull-ups, never hold old data
    assign p0Pin = (~p0OeN & p0Out) | (p0OeN & memOut);
    always @(negedge ale)
        addrQ = {p2Pin, p0Pin};
    // Sampled mid-cycle, away from the strobe edges
    always @(negedge clock)
        if (!writeN)
            store[addrQ] = p0Pin;
endmodule
`default_nettype wire

// file: ext_memory_bus_port_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ext_memory_bus_port_control_tb;
    import emb_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic extAccessSelect = 1'b1;
    logic progVerify = 1'b0, fetchReq = 1'b0, dataReq = 1'b0;
    logic dataWrite = 1'b0, dataWide = 1'b0, serialTxd = 1'b1;
    logic [3:0] latchWe = 4'h0;
    emb_addr_t fetchAddr = '0, dataAddr = '0, intRomAddr;
    emb_byte_t dataWrByte = '0, latchWrByte = '0, intRomData, codeByte, dataRdByte;
    emb_byte_t p1Ext = 8'hff, p2Ext = 8'hff, p3Ext = 8'hff;
    emb_byte_t p0In, p1In, p2In, p3In, p0Out, p1Out, p2Out, p3Out;
    emb_byte_t p0OeN, p1OeN, p2OeN, p3OeN, p0Read, p1Read, p2Read, p3Read;
    logic codeValid, dataDone, dataBusy, serialRxd, extIrq0Pin, extIrq1Pin;
    logic timer0ExtInput, timer1ExtInput, timer2ClockInput, timer2TriggerInput;
    logic addrLatchStrobe, progStoreStrobeN, aleQ = 1'b0, psQ = 1'b1;
    int miscompares = 0, comparisons = 0, aleRises = 0, strobeFalls = 0;

    always #4 clock = ~clock;
    assign intRomData = intRomAddr[7:0] ^ 8'h3c;
    assign p1In = (p1OeN & p1Ext) | (~p1OeN & p1Out);
    assign p2In = (p2OeN & p2Ext) | (~p2OeN & p2Out);
    assign p3In = (p3OeN & p3Ext) | (~p3OeN & p3Out);

    emb_bus_port_ctrl dut
    (
        .clock, .rst, .extAccessSelect, .progVerify, .fetchReq, .fetchAddr, .codeByte,
        .codeValid, .dataReq, .dataWrite, .dataWide, .dataAddr, .dataWrByte, .dataRdByte,
        .dataDone, .dataBusy, .latchWe, .latchWrByte, .p0Read, .p1Read, .p2Read, .p3Read,
        .serialTxd, .serialRxd, .extIrq0Pin, .extIrq1Pin, .timer0ExtInput, .timer1ExtInput,
        .timer2ClockInput, .timer2TriggerInput, .intRomAddr, .intRomData, .addrLatchStrobe,
        .progStoreStrobeN, .p0In, .p0Out, .p0OeN, .p1In, .p1Out, .p1OeN, .p2In, .p2Out,
        .p2OeN, .p3In, .p3Out, .p3OeN
    );

    emb_ext_mem mem
    (
        .clock(clock),
        .ale(addrLatchStrobe),
        .progStrobeN(progStoreStrobeN),
        .readN(p3In[P3_RD]),
        .writeN(p3In[P3_WR]),
        .p0Out(p0Out),
        .p0OeN(p0OeN),
        .p2Pin(p2In),
        .p0Pin(p0In)
    );

    // ----------------------------------------
    // Pulse counters
    // ----------------------------------------
    always @(posedge clock)
    begin
        if (addrLatchStrobe === 1'b1 && aleQ === 1'b0)
            aleRises++;
        if (progStoreStrobeN === 1'b0 && psQ === 1'b1)
            strobeFalls++;
        aleQ = addrLatchStrobe;
        psQ = progStoreStrobeN;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    function automatic emb_byte_t memByte(input emb_addr_t a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    task automatic waitCode(input int times);
        repeat (times)
        begin
            tick(1);
            for (int i = 0; i < 40 && codeValid !== 1'b1; i++)
                tick(1);
        end
        chk(16'(codeValid), 16'h1);
    endtask

    // Window of 24 clocks holds three ALE pulses and two program strobe pulses
    task automatic dataAccess(input logic wr, input logic wide, input emb_addr_t a,
                              input emb_byte_t wd, output emb_byte_t rdb);
        dataWrite = wr;
        dataWide = wide;
        dataAddr = a;
        dataWrByte = wd;
        dataReq = 1'b1;
        rdb = 'x;
        tick(1);
        chk(16'(dataBusy), 16'h1);
        dataReq = 1'b0;
        aleRises = 0;
        strobeFalls = 0;
        repeat (24)
        begin
            tick(1);
            if (dataDone === 1'b1)
                rdb = dataRdByte;
        end
        chk(16'(aleRises), 16'h3);
        chk(16'(strobeFalls), 16'h2);
        chk(16'(dataBusy), 16'h0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset;
        chk({p1OeN, p2OeN}, 16'hffff);
        chk(16'(p3OeN), 16'hff);
        tick(24);
        rst = 1'b0;
        tick(2);
        chk(16'(p0OeN), 16'hff);
        chk({p1In, p3In}, 16'hffff);
        $display("reset test done");
    endtask

    task automatic test_internal;
        fetchAddr = 16'h3ffe;
        fetchReq = 1'b1;
        waitCode(1);
        chk(16'(codeByte), 16'(8'hfe ^ 8'h3c));
        aleRises = 0;
        strobeFalls = 0;
        tick(60);
        chk(16'(aleRises), 16'd10);
        chk(16'(strobeFalls), 16'h0);
        fetchReq = 1'b0;
        $display("internal fetch test done");
    endtask

    task automatic test_external;
        fetchAddr = 16'h4123;
        fetchReq = 1'b1;
        waitCode(2);
        chk(16'(codeByte), 16'(memByte(16'h4123)));
        strobeFalls = 0;
        tick(24);
        chk(16'(strobeFalls), 16'h4);
        extAccessSelect = 1'b0;
        fetchAddr = 16'h0155;
        waitCode(2);
        chk(16'(codeByte), 16'(memByte(16'h0155)));
        $display("external fetch test done");
    endtask

    task automatic test_data;
        emb_byte_t rdb;
        latchWe = 4'h4;
        latchWrByte = 8'h47;
        tick(1);
        latchWe = 4'h0;
        tick(12);
        dataAccess(1'b0, 1'b1, 16'h8a31, 8'h00, rdb);
        chk(16'(rdb), 16'(memByte(16'h8a31)));
        dataAccess(1'b0, 1'b0, 16'h0077, 8'h00, rdb);
        chk(16'(rdb), 16'(memByte(16'h4777)));
        dataAccess(1'b1, 1'b1, 16'h9012, 8'hc6, rdb);
        chk(16'(mem.store[16'h9012]), 16'hc6);
        fetchReq = 1'b0;
        extAccessSelect = 1'b1;
        $display("data access test done");
    endtask

    task automatic test_ports;
        latchWe = 4'ha;
        latchWrByte = 8'hde;
        tick(1);
        latchWe = 4'h0;
        tick(3);
        chk({p1Read, p3Read}, 16'hdede);
        chk(16'({timer2TriggerInput, timer2ClockInput}), 16'h2);
        chk(16'({timer1ExtInput, timer0ExtInput, extIrq1Pin, extIrq0Pin, serialRxd}), 16'he);
        p1Ext = 8'h0f;
        latchWe = 4'h2;
        latchWrByte = 8'hff;
        tick(1);
        latchWe = 4'h0;
        tick(3);
        chk(16'(p1Read), 16'h0f);
        p1Ext = 8'hff;
        $display("port test done");
    endtask

    task automatic test_verify;
        progVerify = 1'b1;
        p1Ext = 8'h34;
        p2Ext = 8'hd2;
        tick(4);
        chk(intRomAddr, 16'h1234);
        chk(16'(p0In), 16'(8'h34 ^ 8'h3c));
        chk({p2Read, p0Read}, {8'hd2, 8'h34 ^ 8'h3c});
        progVerify = 1'b0;
        p1Ext = 8'hff;
        p2Ext = 8'hff;
        $display("verify test done");
    endtask

    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        #1;
        test_reset();
        test_internal();
        test_external();
        test_data();
        test_ports();
        test_verify();
        give_verdict();
    end

    // Whole run is well under a thousand clocks
    initial
    begin
        #20000;
        miscompares++;
        give_verdict();
    end
endmodule
`default_nettype wire
